/* File: logic/cse_pkg.sv */
// Constants shared by the charge status encoder and its blink generator.
// Assumes a single 250 MHz clock and an AXI4-Lite register port of 32 bits.
package cse_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ = 250_000_000; // Core clock rate
    localparam longint CARRIER_HZ = 35_000; // Fault pulse train rate
    localparam longint CARRIER_CYC = CLK_HZ / CARRIER_HZ; // Cycles per carrier period
    localparam longint NTC_BLINK_MHZ = 1_500; // Thermistor fault blink, millihertz
    localparam longint BAD_BLINK_MHZ = 6_100; // Bad battery blink, millihertz
    // Half of a blink period: each duty value is held for this long
    localparam longint NTC_HALF_CYC = (CLK_HZ * 1000) / (2 * NTC_BLINK_MHZ);
    localparam longint BAD_HALF_CYC = (CLK_HZ * 1000) / (2 * BAD_BLINK_MHZ);
    localparam longint BAD_TIMEOUT_S = 1_800; // Trickle timeout, seconds
    localparam longint BAD_TIMEOUT_CYC = CLK_HZ * BAD_TIMEOUT_S;
    localparam longint SAFETY_S = 14_400; // Float safety timer, seconds
    localparam longint SAFETY_CYC = CLK_HZ * SAFETY_S;
    localparam int TIMER_W = 42; // Wide enough for the safety count

    // ------------------------------------------------------------------
    // Duty values in sixteenths of a carrier period (time pulled low)
    // ------------------------------------------------------------------
    localparam logic [4:0] DUTY_DEN = 5'h10;
    localparam logic [4:0] NTC_DUTY_LO = 5'h01;
    localparam logic [4:0] NTC_DUTY_HI = 5'h0f;
    localparam logic [4:0] BAD_DUTY_LO = 5'h02;
    localparam logic [4:0] BAD_DUTY_HI = 5'h0e;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam int CTRL_RESTART_BIT = 0; // Write one: restart a charge cycle
    localparam int CTRL_NTC_EN_BIT = 1; // Thermistor pausing allowed
    localparam logic [31:0] CTRL_RST = 32'h0000_0002;
    localparam int ST_STATE_LSB = 0; // Three bits of charger state
    localparam int ST_TEMP_BIT = 3;
    localparam int ST_PAUSE_BIT = 4;
    localparam int ST_PULL_BIT = 5;
    localparam int ST_ILIM_BIT = 6;
    localparam int ST_EOC_BIT = 7;
    localparam int ST_PIN_BIT = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Charger sequence states
    typedef enum logic [2:0] {
        CSE_IDLE,
        CSE_TRICKLE,
        CSE_CONST_CURR,
        CSE_CONST_VOLT,
        CSE_DONE,
        CSE_BAD
    } cse_state_e;

endpackage : cse_pkg

/* File: logic/cse_blink_pwm.sv */
// Fault pulse train: a carrier whose low-time alternates between two duty
// values every half blink period. Assumes run is a registered level.
module cse_blink_pwm
    import cse_pkg::*;
#(
    parameter int CARRIER = int'(CARRIER_CYC),
    parameter int HALF = int'(NTC_HALF_CYC),
    parameter logic [4:0] DUTY_A = NTC_DUTY_LO,
    parameter logic [4:0] DUTY_B = NTC_DUTY_HI
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    output logic pull_low
);

    // Low-time thresholds in clock cycles for the two duty values
    localparam logic [31:0] TH_A = 32'((longint'(CARRIER) * DUTY_A) / DUTY_DEN);
    localparam logic [31:0] TH_B = 32'((longint'(CARRIER) * DUTY_B) / DUTY_DEN);

    logic [31:0] carrier_cnt; // Position in the carrier period
    logic [31:0] blink_cnt; // Position in the half blink period
    logic phase; // Zero selects DUTY_A
    logic [31:0] next_carrier_cnt;
    logic [31:0] next_blink_cnt;
    logic next_phase;
    logic next_pull_low;

    // ------------------------------------------------------------------
    // Counters and output
    // ------------------------------------------------------------------
    // Restarting from zero on each fault keeps the first blink a full one
    always_comb
    begin
        next_carrier_cnt = '0;
        next_blink_cnt = '0;
        next_phase = 1'b0;
        next_pull_low = 1'b0;
        if (run)
        begin
            next_carrier_cnt = (carrier_cnt == 32'(CARRIER - 1)) ? '0 : carrier_cnt + 32'h1;
            next_blink_cnt = (blink_cnt == 32'(HALF - 1)) ? '0 : blink_cnt + 32'h1;
            next_phase = (blink_cnt == 32'(HALF - 1)) ? ~phase : phase;
            // Low for the first part of each carrier period
            next_pull_low = carrier_cnt < (phase ? TH_B : TH_A);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            carrier_cnt <= '0;
            blink_cnt <= '0;
            phase <= 1'b0;
            pull_low <= 1'b0;
        end
        else
        begin
            carrier_cnt <= next_carrier_cnt;
            blink_cnt <= next_blink_cnt;
            phase <= next_phase;
            pull_low <= next_pull_low;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    blink_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        run && blink_cnt == 32'(HALF - 1) ##1 run |-> phase != $past(phase))
        else $error("blink phase did not alternate");
    duty_window_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        run && carrier_cnt == (phase ? TH_B : TH_A) |=> !pull_low)
        else $error("pulse low past its duty threshold");

endmodule : cse_blink_pwm

/* File: logic/cse_charge_status.sv */
// Charger sequencing and open-drain status encoding with an AXI4-Lite port.
// Assumes comparator inputs are clean synchronous levels from analog logic.
import cse_pkg::*;

// Overview of operation
// R1 - Status: steady low, released, or fault pulses
// R2 - Pull low throughout a normal charge cycle
// R3 - Release at float with current below tenth
// R4 - Ignore tenth-current completion while in current limit
// R5 - Fault: carrier with duty alternating every half-blink
// R6 - Thermistor fault: 6.25/93.75 percent at 1.5 Hz
// R7 - Bad battery: 12.5/87.5 percent at 6.1 Hz
// R8 - Bad battery after half hour below trickle
// R9 - Decoder discards exact half duty readings
// R10 - Host may lower load and restart charger
// R11 - Pause charging when thermistor out of band
// R12 - Freeze safety timer on pause in float
// R13 - Grounded thermistor input disables temperature pausing
// R14 - Output is open drain, never drives high
// R15 - Enable toggle restarts cycle and clears timer
// R16 - Four-hour safety timer from float, then stop
// R17 - Counted timing; faults override charge indications
module cse_charge_status
    import cse_pkg::*;
#(
    parameter int CARRIER_CYCLES = int'(CARRIER_CYC),
    parameter int NTC_HALF_CYCLES = int'(NTC_HALF_CYC),
    parameter int BAD_HALF_CYCLES = int'(BAD_HALF_CYC),
    parameter longint BAD_TIMEOUT_CYCLES = BAD_TIMEOUT_CYC,
    parameter longint SAFETY_CYCLES = SAFETY_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Charger inputs from the analog side
    input wire logic charger_enable_input,
    input wire logic battery_below_trickle,
    input wire logic battery_at_float,
    input wire logic charge_below_tenth,
    input wire logic input_current_limit,
    input wire logic battery_below_recharge,
    input wire logic thermistor_hot,
    input wire logic thermistor_cold,
    input wire logic thermistor_sense_grounded,
    // Open-drain status pin
    input wire logic charge_status_output_in,
    output logic charge_status_output_out,
    output logic charge_status_output_oe,
    // Charger controls
    output logic charge_current_enable,
    output logic trickle_mode
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam logic [TIMER_W-1:0] BAD_LAST = TIMER_W'(BAD_TIMEOUT_CYCLES - 1);
    localparam logic [TIMER_W-1:0] SAFETY_LAST = TIMER_W'(SAFETY_CYCLES - 1);

    cse_state_e state, next_state; // Charger sequence
    logic [TIMER_W-1:0] bad_cnt, next_bad_cnt; // Time spent below trickle
    logic [TIMER_W-1:0] safety_cnt, next_safety_cnt; // Time spent at float
    logic end_of_charge, next_end_of_charge; // Completion seen in float
    logic enable_prev; // Last enable level, for edge detect
    logic next_charge_current_enable;
    logic next_trickle_mode;
    logic next_oe;
    logic ntc_run, next_ntc_run; // Thermistor fault pattern active
    logic bad_run, next_bad_run; // Bad battery pattern active
    logic ntc_pull, bad_pull; // Pattern outputs
    logic temp_fault; // Thermistor out of band and pausing allowed
    logic start_cycle; // Enable edge or software restart
    logic charging; // One of the active charge states
    // Register file
    logic [31:0] ctrl, next_ctrl;
    logic restart_req, next_restart_req;
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [ADDR_W-1:0] waddr, next_waddr;
    logic [31:0] wdata, next_wdata;
    logic [3:0] wstrb, next_wstrb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] status_word;

    // ------------------------------------------------------------------
    // Fault pattern generators
    // ------------------------------------------------------------------
    cse_blink_pwm #(
        .CARRIER(CARRIER_CYCLES),
        .HALF(NTC_HALF_CYCLES),
        .DUTY_A(NTC_DUTY_LO),
        .DUTY_B(NTC_DUTY_HI)
    ) u_ntc_pwm (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ntc_run),
        .pull_low(ntc_pull)
    ); // R6

    cse_blink_pwm #(
        .CARRIER(CARRIER_CYCLES),
        .HALF(BAD_HALF_CYCLES),
        .DUTY_A(BAD_DUTY_LO),
        .DUTY_B(BAD_DUTY_HI)
    ) u_bad_pwm (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(bad_run),
        .pull_low(bad_pull)
    ); // R7

    // ------------------------------------------------------------------
    // Charger sequence
    // ------------------------------------------------------------------
    // Grounded sense input or software bit turns pausing off
    assign temp_fault = ctrl[CTRL_NTC_EN_BIT] && !thermistor_sense_grounded
        && (thermistor_hot || thermistor_cold); // R11 R13
    assign start_cycle = (charger_enable_input && !enable_prev) || restart_req; // R15 R10
    assign charging = state inside {CSE_TRICKLE, CSE_CONST_CURR, CSE_CONST_VOLT};

    always_comb
    begin
        next_state = state;
        next_bad_cnt = bad_cnt;
        next_safety_cnt = safety_cnt;
        next_end_of_charge = end_of_charge;
        if (!charger_enable_input)
        begin
            // Disabled charger shows not charging
            next_state = CSE_IDLE;
        end
        else if (start_cycle)
        begin
            next_state = CSE_TRICKLE; // R15
            next_bad_cnt = '0;
            next_safety_cnt = '0;
            next_end_of_charge = 1'b0;
        end
        else
        begin
            unique case (state)
                CSE_IDLE:
                begin
                    next_state = CSE_IDLE;
                end
                CSE_TRICKLE:
                begin
                    if (!battery_below_trickle)
                        next_state = CSE_CONST_CURR;
                    else if (bad_cnt == BAD_LAST)
                        next_state = CSE_BAD; // R8
                    else if (!temp_fault)
                        next_bad_cnt = bad_cnt + 1'b1; // R8
                end
                CSE_CONST_CURR:
                begin
                    if (battery_at_float)
                    begin
                        next_state = CSE_CONST_VOLT; // R16
                        next_safety_cnt = '0;
                    end
                end
                CSE_CONST_VOLT:
                begin
                    // Completion only counts outside current limit
                    if (battery_at_float && charge_below_tenth && !input_current_limit)
                        next_end_of_charge = 1'b1; // R3 R4
                    if (safety_cnt == SAFETY_LAST)
                        next_state = CSE_DONE; // R16
                    else if (!temp_fault)
                        next_safety_cnt = safety_cnt + 1'b1; // R12
                end
                CSE_DONE:
                begin
                    // Recharge threshold is filtered on the analog side
                    if (battery_below_recharge)
                    begin
                        next_state = CSE_TRICKLE;
                        next_bad_cnt = '0;
                        next_safety_cnt = '0;
                        next_end_of_charge = 1'b0;
                    end
                end
                CSE_BAD:
                begin
                    next_state = CSE_BAD; // Held until restart
                end
                default:
                begin
                    next_state = CSE_IDLE;
                end
            endcase
        end
        next_charge_current_enable = charging && !temp_fault; // R11 R16
        next_trickle_mode = state == CSE_TRICKLE;
        next_bad_run = state == CSE_BAD;
        next_ntc_run = charging && temp_fault;
        // Faults win over charging, charging over released
        if (bad_run)
            next_oe = bad_pull; // R17 R7
        else if (ntc_run)
            next_oe = ntc_pull; // R17 R6
        else
            next_oe = charging && !end_of_charge; // R1 R2 R3
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= CSE_IDLE;
            bad_cnt <= '0;
            safety_cnt <= '0;
            end_of_charge <= 1'b0;
            enable_prev <= 1'b0;
            charge_current_enable <= 1'b0;
            trickle_mode <= 1'b0;
            ntc_run <= 1'b0;
            bad_run <= 1'b0;
            charge_status_output_oe <= 1'b0;
            charge_status_output_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bad_cnt <= next_bad_cnt;
            safety_cnt <= next_safety_cnt;
            end_of_charge <= next_end_of_charge;
            enable_prev <= charger_enable_input;
            charge_current_enable <= next_charge_current_enable;
            trickle_mode <= next_trickle_mode;
            ntc_run <= next_ntc_run;
            bad_run <= next_bad_run;
            charge_status_output_oe <= next_oe;
            charge_status_output_out <= 1'b0; // R14
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite register port
    // ------------------------------------------------------------------
    assign status_word = {23'h0, charge_status_output_in, end_of_charge, input_current_limit,
        charge_status_output_oe, (state == CSE_CONST_VOLT) && temp_fault, temp_fault, state};

    // Address and data are taken in either order, then answered together
    always_comb
    begin
        logic aw_go;
        logic w_go;
        logic do_write;
        aw_go = s_axi_awvalid && s_axi_awready;
        w_go = s_axi_wvalid && s_axi_wready;
        next_aw_held = aw_held || aw_go;
        next_w_held = w_held || w_go;
        next_waddr = aw_go ? s_axi_awaddr : waddr;
        next_wdata = w_go ? s_axi_wdata : wdata;
        next_wstrb = w_go ? s_axi_wstrb : wstrb;
        do_write = next_aw_held && next_w_held && !s_axi_bvalid;
        next_ctrl = ctrl;
        next_restart_req = 1'b0; // Single-cycle request
        next_bresp = s_axi_bresp;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_SLVERR;
            if (next_waddr == CTRL_OFS)
            begin
                next_bresp = RESP_OKAY;
                if (next_wstrb[0])
                begin
                    next_ctrl[7:0] = {6'h0, next_wdata[CTRL_NTC_EN_BIT], 1'b0};
                    next_restart_req = next_wdata[CTRL_RESTART_BIT]; // R10
                end
            end
            else if (next_waddr == STATUS_OFS)
                next_bresp = RESP_OKAY; // Read-only, write ignored
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        // Read side: one outstanding read
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            if (s_axi_araddr == CTRL_OFS)
                next_rdata = ctrl;
            else if (s_axi_araddr == STATUS_OFS)
                next_rdata = status_word;
            else
            begin
                next_rdata = 32'h0;
                next_rresp = RESP_SLVERR;
            end
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= CTRL_RST;
            restart_req <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            waddr <= '0;
            wdata <= '0;
            wstrb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            ctrl <= next_ctrl;
            restart_req <= next_restart_req;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            waddr <= next_waddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        charge_status_output_oe |-> !charge_status_output_out)
        else $error("status pin driven high");
    charge_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        charging && !temp_fault && !end_of_charge && !bad_run && !ntc_run
        |=> charge_status_output_oe)
        else $error("status released during charge");
    done_release_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        state == CSE_DONE && !bad_run && !ntc_run |=> !charge_status_output_oe)
        else $error("status held low after charge end");
    ilim_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        state == CSE_CONST_VOLT && input_current_limit && !end_of_charge
        && charger_enable_input && !start_cycle |=> !end_of_charge)
        else $error("completion taken in current limit");
    timer_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        state == CSE_CONST_VOLT && temp_fault && charger_enable_input && !start_cycle
        |=> $stable(safety_cnt))
        else $error("safety timer ran during pause");
    safety_expire_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        state == CSE_CONST_VOLT && safety_cnt == SAFETY_LAST && charger_enable_input
        && !start_cycle |=> state == CSE_DONE ##1 !charge_current_enable)
        else $error("charge current after safety timeout");
    pause_charge_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        temp_fault |=> !charge_current_enable)
        else $error("charge current during thermistor fault");
    restart_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        charger_enable_input && start_cycle
        |=> state == CSE_TRICKLE && safety_cnt == '0 && bad_cnt == '0)
        else $error("restart did not clear the cycle");
    bad_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        state == CSE_TRICKLE && battery_below_trickle && bad_cnt == BAD_LAST
        && charger_enable_input && !start_cycle |=> state == CSE_BAD ##1 bad_run)
        else $error("bad battery not declared at timeout");

endmodule : cse_charge_status

/* File: dv/cse_pin_model.sv */
// Host-side model of the status pin: a pull-up and a low-time meter.
// Assumes oe high means the device pulls the pin low.
module cse_pin_model (
    input wire logic aclk,
    input wire logic oe,
    output logic pin,
    output logic [7:0] low_len,
    output logic edge_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00; // Low cycles so far
    // Pull-up: a released pin reads high, never a stale level
    assign pin = oe ? 1'b0 : 1'b1;
    // A low pulse ends on a high level; a half-duty reading is dropped
    always @(posedge aclk)
    begin
        edge_seen <= 1'b0;
        if (!pin)
            cnt <= cnt + 8'h01;
        else if (cnt != 8'h00)
        begin
            low_len <= cnt;
            edge_seen <= (cnt != 8'h10);
            cnt <= 8'h00;
        end
    end
endmodule : cse_pin_model

/* File: dv/cse_charge_status_test.sv */
// Bench for the charge status encoder with shortened counts.
// Assumes cse_pin_model stands in for the host on the status pin.
module cse_charge_status_test
    import cse_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, low_len;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, exp_q[$];
    logic charger_enable_input = 1, battery_below_trickle = 1, battery_at_float = 0;
    logic charge_below_tenth = 0, input_current_limit = 0, thermistor_hot = 0;
    logic thermistor_sense_grounded = 0, charge_status_output_in, edge_seen;
    logic thermistor_cold = 0, battery_below_recharge = 0, trickle_mode;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic charge_status_output_out, charge_status_output_oe, charge_current_enable;
    int err_count = 0, n_checks = 0, seed = 32'hd0d7deeb;
    always #2 aclk = ~aclk;
    // Counts shortened so faults and timers fit the run
    cse_charge_status #(.CARRIER_CYCLES(32), .NTC_HALF_CYCLES(256), .BAD_HALF_CYCLES(64),
        .BAD_TIMEOUT_CYCLES(100), .SAFETY_CYCLES(100)) uut (.aclk, .aresetn, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready(1'b1), .s_axi_rdata,
        .s_axi_rresp, .charger_enable_input, .battery_below_trickle, .battery_at_float,
        .charge_below_tenth, .input_current_limit, .battery_below_recharge,
        .thermistor_hot, .thermistor_cold, .thermistor_sense_grounded,
        .charge_status_output_in, .charge_status_output_out, .charge_status_output_oe,
        .charge_current_enable, .trickle_mode);
    cse_pin_model pm (.aclk, .oe(charge_status_output_oe), .pin(charge_status_output_in),
        .low_len, .edge_seen);
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // Write: both channels offered together, each released once taken
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        for (i = 0; i < 50 && !s_axi_bvalid; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        if (i == 50)
        begin
            chk("write wait", 0, 1);
            give_verdict();
        end
        chk("bresp", r, s_axi_bresp);
    endtask : wr
    // Read: expectation is queued for the monitor below
    task automatic rd(logic [7:0] a, logic [31:0] e);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        for (i = 0; i < 50 && !(s_axi_arready && s_axi_arvalid); i++) @(posedge aclk);
        if (i == 50)
        begin
            chk("read wait", 0, 1);
            give_verdict();
        end
        s_axi_arvalid <= 0;
        exp_q.push_back(e);
        repeat (3) @(posedge aclk);
    endtask : rd
    always @(posedge aclk)
        if (s_axi_rvalid) chk("rdata", exp_q.pop_front(), s_axi_rdata);
    // Fault train: every reading after the first two is one of the two duty lengths
    task automatic duty(logic [7:0] lo, logic [7:0] hi);
        int i, n = 0, odd = 0, sl = 0, sh = 0;
        for (i = 0; i < 6000 && n < 40; i++)
        begin
            @(posedge aclk);
            if (edge_seen && n++ > 1)
            begin
                sl |= (low_len == lo);
                sh |= (low_len == hi);
                odd += (low_len != lo && low_len != hi);
            end
        end
        chk("duty lo/hi/odd", 3'b110, {sl[0], sh[0], odd != 0});
    endtask : duty
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd(CTRL_OFS, CTRL_RST);
        rd(8'h08, 0);
        wr(8'h0c, $random(seed), RESP_SLVERR);
        rd(STATUS_OFS, 32'h21);
        chk("trickle", 1, trickle_mode);
        duty(8'h04, 8'h1c);
        battery_below_trickle <= 0;
        wr(CTRL_OFS, 32'h3, RESP_OKAY);
        thermistor_cold <= 1;
        duty(8'h02, 8'h1e);
        thermistor_sense_grounded <= 1;
        thermistor_hot <= 1;
        repeat (40) @(posedge aclk);
        chk("oe grounded", 1, charge_status_output_oe);
        {thermistor_hot, thermistor_cold} <= 2'b00;
        {battery_at_float, charge_below_tenth, input_current_limit} <= 3'b111;
        repeat (10) @(posedge aclk);
        chk("oe ilim", 1, charge_status_output_oe);
        input_current_limit <= 0;
        repeat (6) @(posedge aclk);
        chk("oe eoc", 0, charge_status_output_oe);
        repeat (120) @(posedge aclk);
        chk("current", 0, charge_current_enable);
        battery_below_recharge <= 1;
        repeat (4) @(posedge aclk);
        chk("recharge", 1, charge_current_enable);
        battery_below_recharge <= 0;
        charger_enable_input <= 0;
        repeat (3) @(posedge aclk);
        charger_enable_input <= 1;
        repeat (6) @(posedge aclk);
        chk("current", 1, charge_current_enable);
        give_verdict();
    end
endmodule : cse_charge_status_test
